// File: include/ilfs_pkg.sv
// Package: constants and types for the idle letters feed-out sequencer
package ilfs_pkg;

   // Main shaft revolution rate; one tick per revolution
   localparam int unsigned CLOCK_HZ        = 250000000;
   localparam int unsigned SHAFT_PER_MIN   = 600;
   // Revolutions per second first, so the product never overflows 32 bits
   localparam int unsigned TICK_CYCLES     = CLOCK_HZ / (SHAFT_PER_MIN / 60);
   // Idle delays in seconds, as selectable
   localparam int unsigned DELAY_SHORT_S   = 4;
   localparam int unsigned DELAY_LONG_S    = 16;
   localparam int unsigned DELAY_SHORT_TK  = DELAY_SHORT_S * SHAFT_PER_MIN / 60;
   localparam int unsigned DELAY_LONG_TK   = DELAY_LONG_S * SHAFT_PER_MIN / 60;

   // Code and count widths
   localparam int unsigned CODE_W          = 5;
   localparam logic [4:0]  LETTERS_CODE    = 5'h1F;
   // Front ratchet: one step per six characters (0.6 inch at ten per inch)
   localparam logic [2:0]  FRONT_TEETH     = 3'h6;
   localparam int unsigned STEP_W          = 5;
   // Largest step count, 18 inches in 0.6 inch steps
   localparam logic [4:0]  STEP_MAX        = 5'h1E;
   localparam logic [4:0]  STEP_MAX_SHORT  = 5'h06;

   typedef enum logic [1:0] {
      ILFS_IDLE,
      ILFS_WAIT,
      ILFS_FEED
   } ilfs_mode_t;

endpackage

// File: hw/ilfs_buf2.sv
// Two-entry valid/ready buffer for punch codes
`timescale 1ns/1ps
module ilfs_buf2 (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       srst,
   // Fill side
   input  wire logic       in_valid,
   output logic            in_ready,
   input  wire logic [4:0] in_data,
   // Drain side
   output logic            out_valid,
   input  wire logic       out_ready,
   output logic [4:0]      out_data
);
   import ilfs_pkg::*;

   typedef struct packed {
      logic [1:0][4:0] mem;
      logic            rd;
      logic            wr;
      logic [1:0]      cnt;
   } ilfs_buf_t;

   ilfs_buf_t s;
   ilfs_buf_t next_s;
   logic      push;
   logic      pop;

   ////////////////////////////////////////////////////////////////////
   // Honest full and empty from the count
   assign in_ready  = (s.cnt != 2'h2);
   assign out_valid = (s.cnt != 2'h0);
   assign out_data  = s.mem[s.rd];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      next_s = s;
      if (push) begin
         next_s.mem[s.wr] = in_data;
         next_s.wr        = ~s.wr;
      end
      if (pop) begin
         next_s.rd = ~s.rd;
      end
      next_s.cnt = s.cnt + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // A stalled punch must keep seeing the same code
   a_buf_hold_stall : assert property (@(posedge clock) disable iff (srst)
      out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("buffer dropped code under stall");

endmodule // ilfs_buf2

// File: hw/ilfs_seq.sv
// Idle letters feed-out sequencer: idle timer, metering and punch trigger
`timescale 1ns/1ps

// Function
// - End of message enables the two-stage metering counter, counting from the next tick.
// - Feed-out is released once the front stage leaves its start position.
// - While released, every tick with no character held and room in the punch buffer trips a punch cycle with the letters code.
// - At the terminal position feed-out stops, metering halts and counters return to zero.
// - The terminal count is an input, so the filler length is selectable.
// - After a run the sequencer stays idle until a new character arrives.
// - A character during feed-out ends it at once and is punched normally.
// - A first character overlapping a feed-out punch is held until the punch is clear.
// - Feed-out starts only after a selectable idle delay of 4 or 16 seconds.
// - Length is chosen in 0.6 inch steps up to 3.6 or 18 inches by variant.
// - Each received character clears and re-arms the idle timer.
// - The filler is the letters code with all five positions marked.
module ilfs_seq #(
   parameter int unsigned TICK_DIV  = ilfs_pkg::TICK_CYCLES,
   parameter int unsigned DLY_SHORT = ilfs_pkg::DELAY_SHORT_TK,
   parameter int unsigned DLY_LONG  = ilfs_pkg::DELAY_LONG_TK
) (
   // Clock and reset
   input  wire logic                  clock,
   input  wire logic                  srst,
   // Options
   input  wire logic                  long_delay,
   input  wire logic                  long_variant,
   input  wire logic [4:0]            feed_steps,
   // From the character receiver
   input  wire logic                  char_valid,
   input  wire logic [ilfs_pkg::CODE_W-1:0] char_code,
   // To the punch
   output logic                       punch_valid,
   input  wire logic                  punch_ready,
   output logic [ilfs_pkg::CODE_W-1:0] punch_code,
   // Status
   output logic                       feeding,
   output logic                       tick
);
   import ilfs_pkg::*;

   typedef struct packed {
      ilfs_mode_t  mode;
      logic [31:0] div;
      logic [31:0] idle;
      logic [2:0]  front;
      logic [4:0]  back;
      logic        heard;
      logic        held;
      logic [4:0]  held_code;
      logic        tick;
   } ilfs_state_t;

   ilfs_state_t s;
   ilfs_state_t next_s;
   logic        in_valid;
   logic        in_ready;
   logic [4:0]  in_data;
   logic [4:0]  term;
   logic [31:0] dly;

   // Terminal step clamp for the short and long variants
   function automatic logic [4:0] clamp_steps(input logic [4:0] req, input logic lng);
      logic [4:0] lim;
      lim = lng ? STEP_MAX : STEP_MAX_SHORT;
      clamp_steps = (req == 5'h00) ? 5'h01 : ((req > lim) ? lim : req);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Option decode
   assign term = clamp_steps(feed_steps, long_variant);
   assign dly  = long_delay ? DLY_LONG : DLY_SHORT;

   ////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      next_s   = s;
      in_valid = 1'b0;
      in_data  = LETTERS_CODE;
      // Shaft divider makes the one-cycle tick
      next_s.tick = 1'b0;
      if (s.div >= TICK_DIV - 1) begin
         next_s.div  = '0;
         next_s.tick = 1'b1;
      end else begin
         next_s.div = s.div + 32'h00000001;
      end
      // Received character goes first; held one if the buffer is full
      if (s.held) begin
         in_valid = 1'b1;
         in_data  = s.held_code;
         if (in_ready) begin
            next_s.held = 1'b0;
         end
      end
      if (char_valid) begin
         next_s.heard = 1'b1;
         next_s.idle  = '0;
         if (s.mode == ILFS_FEED) begin
            next_s.mode  = ILFS_IDLE;
            next_s.front = '0;
            next_s.back  = '0;
         end
         if (!s.held && in_ready) begin
            in_valid = 1'b1;
            in_data  = char_code;
         end else begin
            next_s.held      = 1'b1;
            next_s.held_code = char_code;
         end
      end else if (s.tick) begin
         case (s.mode)
            ILFS_IDLE: begin
               if (s.heard) begin
                  next_s.mode = ILFS_WAIT;
                  next_s.idle = '0;
               end
            end
            ILFS_WAIT: begin
               if (s.idle + 32'h00000001 >= dly) begin
                  next_s.mode  = ILFS_FEED;
                  next_s.heard = 1'b0;
                  next_s.front = '0;
                  next_s.back  = '0;
               end else begin
                  next_s.idle = s.idle + 32'h00000001;
               end
            end
            ILFS_FEED: begin
               // Front ratchet steps each tick, back every sixth
               if (s.front != 3'h0 || s.back != 5'h00) begin
                  if (!s.held) begin
                     in_valid = 1'b1;
                     in_data  = LETTERS_CODE;
                  end
               end
               if (s.front == FRONT_TEETH - 3'h1) begin
                  next_s.front = '0;
                  if (s.back + 5'h01 >= term) begin
                     next_s.mode = ILFS_IDLE;
                     next_s.back = '0;
                  end else begin
                     next_s.back = s.back + 5'h01;
                  end
               end else begin
                  next_s.front = s.front + 3'h1;
               end
            end
            default: next_s.mode = ILFS_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clock) begin
      if (srst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Punch path buffer; a stalled punch loses no buffered code, but fillers offered while it is full are dropped
   ilfs_buf2 u_buf (
      .clock     (clock),
      .srst      (srst),
      .in_valid  (in_valid),
      .in_ready  (in_ready),
      .in_data   (in_data),
      .out_valid (punch_valid),
      .out_ready (punch_ready),
      .out_data  (punch_code)
   );

   assign feeding = (s.mode == ILFS_FEED);
   assign tick    = s.tick;

   ////////////////////////////////////////////////////////////////////
   // Checks
   a_char_ends_feed : assert property (@(posedge clock) disable iff (srst)
      char_valid && s.mode == ILFS_FEED |=> s.mode == ILFS_IDLE)
      else $error("feed-out not ended by character");
   a_feed_needs_char : assert property (@(posedge clock) disable iff (srst)
      s.mode == ILFS_IDLE && !s.heard && !char_valid |=> s.mode == ILFS_IDLE)
      else $error("restart without character");
   a_idle_rearm : assert property (@(posedge clock) disable iff (srst)
      char_valid |=> s.idle == 32'h0 && s.heard)
      else $error("idle timer not cleared");
   a_char_wins : assert property (@(posedge clock) disable iff (srst)
      char_valid && !s.held && in_ready |-> in_data == char_code)
      else $error("filler beat character");
   a_no_lost_char : assert property (@(posedge clock) disable iff (srst)
      char_valid && !in_ready |=> s.held && s.held_code == $past(char_code))
      else $error("first character lost");
   a_filler_code : assert property (@(posedge clock) disable iff (srst)
      in_valid && !char_valid && !s.held |-> in_data == 5'h1F)
      else $error("filler not letters");
   a_tick_only : assert property (@(posedge clock) disable iff (srst)
      s.mode == ILFS_WAIT && !s.tick && !char_valid |=> $stable(s.idle))
      else $error("timer moved without tick");
   a_meter_start : assert property (@(posedge clock) disable iff (srst)
      $rose(s.mode == ILFS_FEED) |-> s.front == 3'h0 && s.back == 5'h00)
      else $error("meter not at start");
   a_meter_stop : assert property (@(posedge clock) disable iff (srst)
      $fell(s.mode == ILFS_FEED) |-> s.front == 3'h0 && s.back == 5'h00)
      else $error("meter not returned");
   a_first_quiet : assert property (@(posedge clock) disable iff (srst)
      s.mode == ILFS_FEED && s.front == 3'h0 && s.back == 5'h00 && !char_valid
      && !s.held |-> !in_valid)
      else $error("released at start");
   a_feed_punch : assert property (@(posedge clock) disable iff (srst)
      s.tick && s.mode == ILFS_FEED && s.front != 3'h0 && !char_valid && !s.held
      |-> in_valid)
      else $error("missed filler");

endmodule // ilfs_seq

// File: verif/ilfs_punch_model.sv
// Behavioural punch: accepts codes, can stall, keeps counts and history
`timescale 1ns/1ps
module ilfs_punch_model (
   // Clock and bench control
   input  wire logic        clock,
   input  wire logic        clr,
   input  wire logic        stall,
   // Punch side of the sequencer
   input  wire logic        punch_valid,
   output logic             punch_ready,
   input  wire logic [4:0]  punch_code,
   // Observations
   output logic [7:0]       n_letters,
   output logic [7:0]       n_other,
   output logic [14:0]      hist
);
   // Ready drops while stalled, as a slow mechanism would
   assign punch_ready = ~stall;

   ////////////////////////////////////////////////////////////////
   // Count fillers apart from received codes; keep last three received codes
   always_ff @(posedge clock) begin
      if (clr) begin
         n_letters <= 8'h00;
         n_other   <= 8'h00;
         hist      <= 15'h0000;
      end else if (punch_valid && punch_ready) begin
         if (punch_code == 5'h1F) begin
            n_letters <= n_letters + 8'h01;
         end else begin
            n_other <= n_other + 8'h01;
            hist    <= {hist[9:0], punch_code};
         end
      end
   end
endmodule // ilfs_punch_model

// File: verif/ilfs_seq_tb_top.sv
// Testbench for the idle letters feed-out sequencer
`timescale 1ns/1ps
module ilfs_seq_tb_top;
   import ilfs_pkg::*;
   localparam int unsigned DS = 3;
   localparam int unsigned DL = 5;
   logic        clock = 1'b0, srst = 1'b1, clr = 1'b1, stall = 1'b0;
   logic        long_delay = 1'b0, long_variant = 1'b0, char_valid = 1'b0;
   logic [4:0]  feed_steps = 5'h01, char_code = 5'h00, punch_code;
   logic        punch_valid, punch_ready, feeding, tick;
   logic [7:0]  n_letters, n_other;
   logic [14:0] hist;
   int          errors = 0, checks_done = 0, nt;

   // 250 MHz clock
   always #2 clock = ~clock;

   ilfs_seq #(.TICK_DIV(4), .DLY_SHORT(DS), .DLY_LONG(DL)) dut (
      .clock(clock), .srst(srst), .long_delay(long_delay), .long_variant(long_variant),
      .feed_steps(feed_steps), .char_valid(char_valid), .char_code(char_code),
      .punch_valid(punch_valid), .punch_ready(punch_ready), .punch_code(punch_code),
      .feeding(feeding), .tick(tick));
   ilfs_punch_model pm (
      .clock(clock), .clr(clr), .stall(stall), .punch_valid(punch_valid),
      .punch_ready(punch_ready), .punch_code(punch_code), .n_letters(n_letters),
      .n_other(n_other), .hist(hist));

   ////////////////////////////////////////////////////////////////
   // Closing report, reached from the main flow or a timeout
   task automatic end_sim();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Exact value compare
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Range compare, for tick counts the design may place one tick apart
   task automatic cmp_rng(input logic [31:0] got, input int lo, input int hi);
      checks_done++;
      if ($isunknown(got) || got < lo || got > hi) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask

   ////////////////////////////////////////////////////////////////
   // Receiver pulse; code goes to its inverse once no longer valid
   task automatic send_char(input logic [4:0] c);
      @(negedge clock);
      char_valid = 1'b1;
      char_code  = c;
      @(negedge clock);
      char_valid = 1'b0;
      char_code  = ~c;
   endtask

   task automatic clear_counts();
      @(negedge clock);
      clr = 1'b1;
      @(negedge clock);
      clr = 1'b0;
   endtask

   // Bounded wait for a feeding level, counting shaft ticks
   task automatic wait_feed(input logic lvl, output int n_ticks);
      int n;
      n_ticks = 0;
      for (n = 0; n < 3000 && feeding !== lvl; n++) begin
         @(negedge clock);
         if (tick === 1'b1) n_ticks++;
      end
      if (feeding !== lvl) begin
         errors++;
         end_sim();
      end
   endtask

   ////////////////////////////////////////////////////////////////
   // One full run after a message; letters counted at the punch
   task automatic run_feed(input logic ld, input logic lv, input logic [4:0] st,
                           input logic [7:0] exp_l, input int dly);
      long_delay   = ld;
      long_variant = lv;
      feed_steps   = st;
      clear_counts();
      send_char(5'h0A);
      wait_feed(1'b1, nt);
      cmp_rng(nt, dly, dly + 2);
      wait_feed(1'b0, nt);
      repeat (8) @(negedge clock);
      cmp({8'h00, n_letters}, {8'h00, exp_l});
      cmp({8'h00, n_other}, 16'h0001);
      cmp({11'h000, hist[4:0]}, 16'h000A);
   endtask

   // After a run nothing starts again without a new character
   task automatic no_restart();
      int n, seen;
      seen = 0;
      clear_counts();
      for (n = 0; n < 300; n++) begin
         @(negedge clock);
         if (feeding !== 1'b0) seen++;
      end
      cmp(seen[15:0], 16'h0000);
      cmp({8'h00, n_letters}, 16'h0000);
   endtask

   // A character mid-run stops feeding and is punched, not lost
   task automatic char_in_feed();
      long_delay   = 1'b0;
      long_variant = 1'b0;
      feed_steps   = 5'h06;
      clear_counts();
      send_char(5'h03);
      wait_feed(1'b1, nt);
      repeat (13) @(negedge clock);
      send_char(5'h11);
      cmp({15'h0000, feeding}, 16'h0000);
      repeat (6) @(negedge clock);
      cmp({8'h00, n_other}, 16'h0002);
      cmp({1'b0, hist}, {6'h00, 5'h03, 5'h11});
      cmp_rng(n_letters, 1, 3);
      wait_feed(1'b1, nt);
      wait_feed(1'b0, nt);
   endtask

   // Punch stalls while three characters arrive; order must hold
   task automatic stalled_chars();
      clear_counts();
      stall = 1'b1;
      send_char(5'h01);
      send_char(5'h02);
      send_char(5'h04);
      repeat (2) @(negedge clock);
      cmp({15'h0000, punch_valid}, 16'h0001);
      stall = 1'b0;
      repeat (6) @(negedge clock);
      cmp({1'b0, hist}, {1'b0, 5'h01, 5'h02, 5'h04});
      wait_feed(1'b1, nt);
      wait_feed(1'b0, nt);
   endtask

   ////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (8) @(negedge clock);
      srst = 1'b0;
      clr  = 1'b0;
      cmp({14'h0000, punch_valid, feeding}, 16'h0000);
      run_feed(1'b0, 1'b0, 5'h01, 8'h05, DS);
      no_restart();
      run_feed(1'b1, 1'b1, 5'h07, 8'h29, DL);
      run_feed(1'b0, 1'b0, 5'h09, 8'h23, DS);
      run_feed(1'b0, 1'b1, 5'h00, 8'h05, DS);
      char_in_feed();
      stalled_chars();
      end_sim();
   end
endmodule // ilfs_seq_tb_top
